// >>> src/pulse_timing_pkg.sv
// ===========================================================
// Shared constants for the pulse timing register bank
package pulse_timing_pkg;

    // ===========================================================
    // Widths
    localparam int DATA_W  = 32;
    localparam int REG_W   = 24;
    localparam int EDGE_W  = 16;
    localparam int IDX_W   = 6;
    localparam int ADDR_W  = 8;
    localparam int ENTRIES = 6;

    // ===========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] CONTROL_RESET_READBACK_IDX   = 6'h00;
    localparam logic [5:0] SECOND_LED_SAMPLE_START_IDX  = 6'h01;
    localparam logic [5:0] SECOND_LED_SAMPLE_END_IDX    = 6'h02;
    localparam logic [5:0] FIRST_LED_ON_START_IDX       = 6'h03;
    localparam logic [5:0] FIRST_LED_ON_END_IDX         = 6'h04;
    localparam logic [5:0] AMBIENT_TWO_SAMPLE_START_IDX = 6'h05;
    localparam logic [5:0] AMBIENT_TWO_SAMPLE_END_IDX   = 6'h06;
    localparam logic [5:0] SAMPLE_RESULT_IDX            = 6'h2a;
    localparam logic [5:0] TIMING_COUNT_IDX             = 6'h3e;

    // ===========================================================
    // Control field positions
    localparam int READBACK_BIT     = 0;
    localparam int COUNTER_HOLD_BIT = 1;
    localparam int SOFT_RESET_BIT   = 3;

    // ===========================================================
    // Reset values
    localparam logic        CONTROL_BIT_RESET = 1'h0;
    localparam logic [15:0] EDGE_RESET        = 16'h0000;
    localparam logic [15:0] COUNT_RESET       = 16'h0000;

    // ===========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> src/edge_reg_store.sv
`timescale 1ns/1ns
`default_nettype none
// ===========================================================
// Phase edge storage, one word per entry, byte-lane writes
module edge_reg_store #(
    parameter int ENTRIES = 6,
    parameter int WIDTH   = 16
) (
    input  wire logic                         clk,     // System clock
    input  wire logic                         ce,      // Clock enable
    input  wire logic                         clear,   // Sync clear all
    input  wire logic                         wrEn,    // Write strobe
    input  wire logic [$clog2(ENTRIES)-1:0]   wrEntry, // Entry written
    input  wire logic [WIDTH-1:0]             wrData,  // Write data
    input  wire logic [WIDTH/8-1:0]           wrMask,  // Byte lanes
    output logic      [ENTRIES*WIDTH-1:0]     values   // All entries
);

    // ===========================================================
    // One register group per entry and byte lane
    genvar e;
    genvar b;
    generate
        for (e = 0; e < ENTRIES; e++)
        begin : gEntry
            for (b = 0; b < WIDTH / 8; b++)
            begin : gByte
                // Clear outranks a write so soft reset is complete
                always_ff @(posedge clk)
                begin
                    if (ce)
                    begin
                        if (clear)
                            values[e*WIDTH+b*8 +: 8] <= 8'h00;
                        else if (wrEn && wrMask[b] &&
                                 wrEntry == ($clog2(ENTRIES))'(e))
                            values[e*WIDTH+b*8 +: 8] <= wrData[b*8 +: 8];
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> src/pulse_timing_control_regs.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1: Writing control bit 3 soft-resets, self-clearing
// R2: Control bit 1 holds timing counter at zero
// R3: Readback bit set returns stored configuration
// R4: Readback bit clear means configuration write mode
// R5: Result register readable whatever readback bit
// R6: Index 5 holds 16-bit ambient-two start, reset zero
// R7: Index 6 holds 16-bit ambient-two end, reset zero
// R8: Indices 1-4 hold 16-bit edges; upper zero
module pulse_timing_control_regs #(
    parameter logic [15:0] PERIOD_MAX = 16'hffff
) (
    input  wire logic        clk,                    // 10 MHz clock
    input  wire logic        rst,                    // Sync reset, high
    input  wire logic        ce,                     // Clock enable
    input  wire logic [7:0]  awaddr,                 // Write address
    input  wire logic        awvalid,                // Write addr valid
    output logic             awready,                // Write addr ready
    input  wire logic [31:0] wdata,                  // Write data
    input  wire logic [3:0]  wstrb,                  // Write strobes
    input  wire logic        wvalid,                 // Write data valid
    output logic             wready,                 // Write data ready
    output logic [1:0]       bresp,                  // Write response
    output logic             bvalid,                 // Response valid
    input  wire logic        bready,                 // Response ready
    input  wire logic [7:0]  araddr,                 // Read address
    input  wire logic        arvalid,                // Read addr valid
    output logic             arready,                // Read addr ready
    output logic [31:0]      rdata,                  // Read data
    output logic [1:0]       rresp,                  // Read response
    output logic             rvalid,                 // Read data valid
    input  wire logic        rready,                 // Read data ready
    input  wire logic [23:0] sampleResult,           // Conversion result
    output logic [15:0]      timingCount,            // Timing counter
    output logic             softResetPulse,         // Soft reset pulse
    output logic             readbackEnable,         // Readback mode
    output logic             timingCounterHold,      // Counter held
    output logic             secondLedSampleActive,  // Phase window
    output logic             firstLedOnActive,       // Phase window
    output logic             ambientTwoSampleActive  // Phase window
);

    // ===========================================================
    // Write channel holding registers
    logic [7:0]  awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0]  wStrbHeld;

    wire [5:0] wrIdx     = awAddrHeld[7:2];
    wire       wrControl =
        wrIdx == pulse_timing_pkg::CONTROL_RESET_READBACK_IDX;
    wire       wrEdge    =
        wrIdx >= pulse_timing_pkg::SECOND_LED_SAMPLE_START_IDX &&
        wrIdx <= pulse_timing_pkg::AMBIENT_TWO_SAMPLE_END_IDX;
    wire       doWrite   = ce && !awready && !wready && !bvalid;
    wire       ctrlWrite = doWrite && wrControl && wStrbHeld[0];
    wire [2:0] wrEntry   = 3'(wrIdx - 6'h01);
    // Configuration writes only land in write mode
    wire       edgeWrite = doWrite && wrEdge && !readbackEnable; // [R4]

    // ===========================================================
    // Write address / data capture, in either order
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= pulse_timing_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (awvalid && awready)
                awready <= 1'b0;
            if (wvalid && wready)
                wready <= 1'b0;
            if (doWrite)
            begin
                bvalid <= 1'b1;
                bresp  <= (wrControl || wrEdge) ?
                          pulse_timing_pkg::RESP_OKAY :
                          pulse_timing_pkg::RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Payload registers, no reset needed
    always_ff @(posedge clk)
    begin
        if (ce && awvalid && awready)
            awAddrHeld <= awaddr;
        if (ce && wvalid && wready)
        begin
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
        end
    end

    // ===========================================================
    // Control bits; soft reset is a one-cycle pulse, never stored
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            softResetPulse    <= pulse_timing_pkg::CONTROL_BIT_RESET;
            readbackEnable    <= pulse_timing_pkg::CONTROL_BIT_RESET;
            timingCounterHold <= pulse_timing_pkg::CONTROL_BIT_RESET;
        end
        else if (ce)
        begin
            softResetPulse <= ctrlWrite &&
                wDataHeld[pulse_timing_pkg::SOFT_RESET_BIT]; // [R1]
            if (softResetPulse)
            begin
                readbackEnable    <= pulse_timing_pkg::CONTROL_BIT_RESET;
                timingCounterHold <= pulse_timing_pkg::CONTROL_BIT_RESET;
            end
            else if (ctrlWrite)
            begin
                readbackEnable    <=
                    wDataHeld[pulse_timing_pkg::READBACK_BIT]; // [R3] [R4]
                timingCounterHold <=
                    wDataHeld[pulse_timing_pkg::COUNTER_HOLD_BIT]; // [R2]
            end
        end
    end

    // ===========================================================
    // Edge count storage, cleared by either reset only while ce is high
    logic [pulse_timing_pkg::ENTRIES*pulse_timing_pkg::EDGE_W-1:0] edgeValues;

    edge_reg_store #(
        .ENTRIES (pulse_timing_pkg::ENTRIES),
        .WIDTH   (pulse_timing_pkg::EDGE_W)
    ) uStore (
        .clk     (clk),
        .ce      (ce),
        .clear   (rst || softResetPulse),   // [R1] [R6] [R7] [R8]
        .wrEn    (edgeWrite),               // [R6] [R7] [R8]
        .wrEntry (wrEntry),
        .wrData  (wDataHeld[15:0]),         // Upper bits are dropped
        .wrMask  (wStrbHeld[1:0]),
        .values  (edgeValues)
    );

    // Named views of the stored edges
    wire [15:0] secondLedSampleBegin  = edgeValues[15:0];
    wire [15:0] secondLedSampleFinish = edgeValues[31:16];
    wire [15:0] firstLedOnBegin       = edgeValues[47:32];
    wire [15:0] firstLedOnFinish      = edgeValues[63:48];
    wire [15:0] ambientTwoSampleBegin  = edgeValues[79:64];
    wire [15:0] ambientTwoSampleFinish = edgeValues[95:80];

    // ===========================================================
    // Read decode and data selection
    wire [5:0]  arIdx    = araddr[7:2];
    wire [2:0]  rdEntry  = 3'(arIdx - 6'h01);
    wire        rdControl =
        arIdx == pulse_timing_pkg::CONTROL_RESET_READBACK_IDX;
    wire        rdEdge   =
        arIdx >= pulse_timing_pkg::SECOND_LED_SAMPLE_START_IDX &&
        arIdx <= pulse_timing_pkg::AMBIENT_TWO_SAMPLE_END_IDX;
    wire        rdResult = arIdx == pulse_timing_pkg::SAMPLE_RESULT_IDX;
    wire        rdCount  = arIdx == pulse_timing_pkg::TIMING_COUNT_IDX;
    wire        rdMapped = rdControl || rdEdge || rdResult || rdCount;
    wire [15:0] edgeSel  = edgeValues[rdEntry*pulse_timing_pkg::EDGE_W +: 16];
    // Config reads are blanked in write mode; results never are
    wire [31:0] edgeWord = readbackEnable ? {16'h0000, edgeSel} :
                           32'h00000000;             // [R3] [R4]
    wire [31:0] readWord =
        rdEdge   ? edgeWord :
        rdResult ? {8'h00, sampleResult} :           // [R5]
        rdCount  ? {16'h0000, timingCount} :
                   32'h00000000;

    // ===========================================================
    // Read channel, data registered one cycle after address
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= pulse_timing_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= readWord;
                rresp   <= rdMapped ? pulse_timing_pkg::RESP_OKAY :
                                      pulse_timing_pkg::RESP_SLVERR;
            end
            else if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ===========================================================
    // Pulse timing counter; held or soft reset forces zero
    wire counterZero = softResetPulse || timingCounterHold; // [R1] [R2]
    wire atWrap      = timingCount == PERIOD_MAX;

    always_ff @(posedge clk)
    begin
        if (rst)
            timingCount <= pulse_timing_pkg::COUNT_RESET;
        else if (ce)
        begin
            if (counterZero || atWrap)
                timingCount <= pulse_timing_pkg::COUNT_RESET; // [R2]
            else
                timingCount <= timingCount + 16'h0001;
        end
    end

    // ===========================================================
    // Phase windows, inclusive of both edges, off while held
    wire inSecondLed = timingCount >= secondLedSampleBegin &&
                       timingCount <= secondLedSampleFinish;
    wire inFirstLed  = timingCount >= firstLedOnBegin &&
                       timingCount <= firstLedOnFinish;
    wire inAmbient   = timingCount >= ambientTwoSampleBegin &&
                       timingCount <= ambientTwoSampleFinish;

    // Registered so the outputs never glitch on compare ripple
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            secondLedSampleActive  <= 1'b0;
            firstLedOnActive       <= 1'b0;
            ambientTwoSampleActive <= 1'b0;
        end
        else if (ce)
        begin
            secondLedSampleActive  <= inSecondLed && !counterZero;
            firstLedOnActive       <= inFirstLed && !counterZero;
            ambientTwoSampleActive <= inAmbient && !counterZero; // [R6]
        end
    end

    // ===========================================================
    // Checks
    soft_reset_clear_a: assert property ( // [R1]
        @(posedge clk) disable iff (rst)
        ce && softResetPulse |=> !softResetPulse && timingCount == 16'h0000
            && !readbackEnable && edgeValues == '0)
        else $error("soft reset did not clear state or self-clear");

    soft_reset_trig_a: assert property ( // [R1]
        @(posedge clk) disable iff (rst)
        ce && ctrlWrite && wDataHeld[3] |=> softResetPulse)
        else $error("soft reset not raised after control write");

    counter_hold_a: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        ce && timingCounterHold |=> timingCount == 16'h0000
            && !firstLedOnActive)
        else $error("timing counter moved while held");

    // The release edge is not disabled, so reset sits in the antecedent
    counter_run_a: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        !rst && ce && !counterZero && timingCount != PERIOD_MAX
        |=> timingCount == $past(timingCount) + 16'h0001)
        else $error("timing counter did not advance");

    readback_on_a: assert property ( // [R3]
        @(posedge clk) disable iff (rst)
        ce && arvalid && arready && readbackEnable && arIdx == 6'h05
        |=> rvalid && rdata == {16'h0000, $past(ambientTwoSampleBegin)})
        else $error("readback did not return stored edge");

    write_mode_blank_a: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        ce && arvalid && arready && !readbackEnable && rdEdge
        |=> rvalid && rdata == 32'h00000000)
        else $error("configuration visible in write mode");

    result_read_a: assert property ( // [R5]
        @(posedge clk) disable iff (rst)
        ce && arvalid && arready && rdResult
        |=> rdata == {8'h00, $past(sampleResult)} && rresp == 2'h0)
        else $error("result read not returned");

    amb_start_store_a: assert property ( // [R6]
        @(posedge clk) disable iff (rst)
        doWrite && wrIdx == 6'h05 && wStrbHeld[1:0] == 2'h3
            && !readbackEnable && !softResetPulse
        |=> ambientTwoSampleBegin == $past(wDataHeld[15:0]))
        else $error("ambient two start not stored");

    amb_end_store_a: assert property ( // [R7]
        @(posedge clk) disable iff (rst)
        doWrite && wrIdx == 6'h06 && wStrbHeld[1:0] == 2'h3
            && !readbackEnable && !softResetPulse
        |=> ambientTwoSampleFinish == $past(wDataHeld[15:0]))
        else $error("ambient two end not stored");

    led_edge_store_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        doWrite && wrIdx == 6'h03 && wStrbHeld[1:0] == 2'h3
            && !readbackEnable && !softResetPulse
        |=> firstLedOnBegin == $past(wDataHeld[15:0]))
        else $error("led one start not stored");

    led_two_start_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        doWrite && wrIdx == 6'h01 && wStrbHeld[1:0] == 2'h3
            && !readbackEnable && !softResetPulse
        |=> secondLedSampleBegin == $past(wDataHeld[15:0]))
        else $error("led two start not stored");

    led_two_end_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        doWrite && wrIdx == 6'h02 && wStrbHeld[1:0] == 2'h3
            && !readbackEnable && !softResetPulse
        |=> secondLedSampleFinish == $past(wDataHeld[15:0]))
        else $error("led two end not stored");

    led_one_end_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        doWrite && wrIdx == 6'h04 && wStrbHeld[1:0] == 2'h3
            && !readbackEnable && !softResetPulse
        |=> firstLedOnFinish == $past(wDataHeld[15:0]))
        else $error("led one end not stored");

    // Edge writes refused in readback mode must leave every stored edge alone
    readback_write_block_a: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        doWrite && wrEdge && readbackEnable && !softResetPulse
        |=> $stable(edgeValues))
        else $error("edge changed by write in readback mode");

    edge_upper_zero_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        ce && arvalid && arready && rdEdge
        |=> rdata[31:16] == 16'h0000)
        else $error("edge read shows upper bits");

endmodule
`default_nettype wire

// >>> test/axi_lite_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ===========================================================
// Host side of the register port, one transfer at a time
module axi_lite_host_model (
    input  wire logic        clk,     // Bus clock
    output var  logic [7:0]  awaddr,  // Write address
    output var  logic        awvalid, // Write addr valid
    input  wire logic        awready, // Write addr ready
    output var  logic [31:0] wdata,   // Write data
    output var  logic [3:0]  wstrb,   // Write strobes
    output var  logic        wvalid,  // Write data valid
    input  wire logic        wready,  // Write data ready
    input  wire logic [1:0]  bresp,   // Write response
    input  wire logic        bvalid,  // Response valid
    output var  logic        bready,  // Response ready
    output var  logic [7:0]  araddr,  // Read address
    output var  logic        arvalid, // Read addr valid
    input  wire logic        arready, // Read addr ready
    input  wire logic [31:0] rdata,   // Read data
    input  wire logic [1:0]  rresp,   // Read response
    input  wire logic        rvalid,  // Read data valid
    output var  logic        rready   // Read data ready
);
    // Idle bus from time zero
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid} = '0;
        {bready, araddr, arvalid, rready} = '0;
    end

    // One write; released lines show inverted junk, not stale data
    task automatic writeReg(input logic [5:0] idx, input logic [15:0] data,
                            output logic [1:0] resp);
        @(posedge clk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, data}; // Upper bits sent as zero
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready)
            begin
                awvalid <= 1'b0;
                awaddr  <= ~awaddr;
            end
            if (wvalid && wready)
            begin
                wvalid <= 1'b0;
                wdata  <= ~wdata;
            end
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask

    // One read, data taken at the handshake edge
    task automatic readReg(input logic [5:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
        @(posedge clk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready)
            begin
                arvalid <= 1'b0;
                araddr  <= ~araddr;
            end
        end while (!(rvalid && rready));
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/pulse_timing_control_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ===========================================================
// Register bank bench: bus calls with expected values
module pulse_timing_control_regs_tb_top;
    localparam logic [1:0] OK = pulse_timing_pkg::RESP_OKAY;
    localparam logic [1:0] ER = pulse_timing_pkg::RESP_SLVERR;
    localparam logic [15:0] EDGES [6] = '{16'h0002, 16'h0004, 16'h0006,
                                          16'h0008, 16'h000a, 16'h000c};
    logic        clk, rst, ce, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready;
    logic        softResetPulse, readbackEnable, timingCounterHold;
    logic        secondLedSampleActive, firstLedOnActive;
    logic        ambientTwoSampleActive;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [23:0] sampleResult;
    logic [15:0] timingCount, prev;
    int          failures = 0, nTests = 0, cycles = 0, pulses = 0;

    pulse_timing_control_regs #(.PERIOD_MAX(16'h0010)) dut_u (
        .clk(clk), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sampleResult(sampleResult), .timingCount(timingCount),
        .softResetPulse(softResetPulse), .readbackEnable(readbackEnable),
        .timingCounterHold(timingCounterHold),
        .secondLedSampleActive(secondLedSampleActive),
        .firstLedOnActive(firstLedOnActive),
        .ambientTwoSampleActive(ambientTwoSampleActive));

    axi_lite_host_model host_u (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // ===========================================================
    // Clock, pulse counter and hang guard
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (softResetPulse === 1'b1)
            pulses++;
        if (cycles == 6000)
        begin
            failures++;
            conclude();
        end
    end

    // ===========================================================
    // Shared compare, bus wrappers and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] data,
                      input logic [1:0] er);
        host_u.writeReg(idx, data, rsp);
        check(rsp, er);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [31:0] ed,
                       input logic [1:0] er);
        host_u.readReg(idx, rd, rsp);
        check(rd, ed);
        check(rsp, er);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ===========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        sampleResult = 24'h000000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values; edge writes refused in readback mode
        wr(6'h00, 16'h0001, OK);
        check(readbackEnable, 1'b1);
        for (int i = 1; i <= 6; i++)
        begin
            rdc(6'(i), 32'h0, OK);
            wr(6'(i), 16'hffff, OK);
            rdc(6'(i), 32'h0, OK);
        end
        // Write mode stores but does not read back
        wr(6'h00, 16'h0000, OK);
        for (int i = 1; i <= 6; i++)
            wr(6'(i), EDGES[i-1], OK);
        rdc(6'h01, 32'h0, OK);
        sampleResult <= 24'ha5c3e1;
        rdc(pulse_timing_pkg::SAMPLE_RESULT_IDX, 32'h00a5c3e1, OK);
        wr(6'h00, 16'h0001, OK);
        for (int i = 1; i <= 6; i++)
            rdc(6'(i), {16'h0000, EDGES[i-1]}, OK);
        rdc(pulse_timing_pkg::SAMPLE_RESULT_IDX, 32'h00a5c3e1, OK);
        // Unmapped read and read-only write are refused
        rdc(6'h10, 32'h0, ER);
        wr(pulse_timing_pkg::SAMPLE_RESULT_IDX, 16'h1111, ER);
        // Counter held at zero, then released
        wr(6'h00, 16'h0003, OK);
        check(timingCounterHold, 1'b1);
        repeat (5) @(posedge clk);
        check(timingCount, 16'h0000);
        rdc(pulse_timing_pkg::TIMING_COUNT_IDX, 32'h0, OK);
        wr(6'h00, 16'h0001, OK);
        // Phase windows follow the stored edges, one cycle late
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk);
            prev = timingCount;
            #1;
            check(secondLedSampleActive, prev >= 2 && prev <= 4);
            check(firstLedOnActive, prev >= 6 && prev <= 8);
            check(ambientTwoSampleActive, prev >= 10 && prev <= 12);
        end
        // Clock enable low freezes the counter
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        prev = timingCount;
        repeat (3) @(posedge clk);
        check(timingCount, prev);
        ce <= 1'b1;
        // Soft reset pulses once and clears configuration
        wr(6'h00, 16'h0008, OK);
        repeat (4) @(posedge clk);
        check(pulses, 1);
        check(readbackEnable, 1'b0);
        wr(6'h00, 16'h0001, OK);
        for (int i = 1; i <= 6; i++)
            rdc(6'(i), 32'h0, OK);
        check(pulses, 1);
        conclude();
    end
endmodule
`default_nettype wire
